// file: gate3_cell_pkg.sv
// Function
// RULE1: The cell keeps evaluating its inputs and driving its output during Sleep with no need for the system clock.
// RULE2: While the cell is enabled and the fast internal oscillator is a selected input, the oscillator is kept running in Sleep.
// RULE3: With that oscillator as both system clock and enabled cell input, Sleep halts the processor while cell and oscillator run.
// RULE4: Select bits 7, 5, 3 and 1 admit the true copy of data inputs 4, 3, 2 and 1 into gate 3.
// RULE5: Select bits 6, 4, 2 and 0 admit the inverted copy of data inputs 4, 3, 2 and 1 into gate 3.
// RULE6: A select bit at one routes its copy into gate 3 and at zero keeps it out.
// RULE7: The eight gate 3 select bits are read/write, unknown at power-up and kept across other resets.
// RULE8: Each of the four data inputs comes from its own multiplexer choosing one of 32 signals.
// RULE9: A reset clears only the main control register and keeps input and gate selections.
// RULE10: Gate 3 is the OR of all admitted copies and is zero when none is admitted.
package gate3_cell_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_SRC = 32;
  localparam int SRC_SEL_W = 5;
  localparam int NUM_DATA = 4;
  localparam int GATE_SEL_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] SRC_SEL0_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] SRC_SEL1_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] SRC_SEL2_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] SRC_SEL3_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] GATE3_SEL_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h18;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [SRC_SEL_W-1:0] FAST_OSC_SRC = 5'h1e;
  localparam int ST_GATE3_BIT = 0;
  localparam int ST_DATA_LSB = 1;
  localparam int ST_OSC_BIT = 5;
  localparam int ST_HALT_BIT = 6;
  localparam int ST_EN_BIT = 7;
  typedef logic [SRC_SEL_W-1:0] src_sel_t;
  typedef struct packed {
    logic enabled;
    logic cpu_halt;
    logic osc_keep;
    logic [NUM_DATA-1:0] data;
    logic gate3;
  } status_s;
endpackage : gate3_cell_pkg

// file: gate3_cell.sv
`timescale 1ns/1ps
module gate3_cell (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gate3_cell_pkg::ADDR_W-1:0] paddr,
  input wire logic [gate3_cell_pkg::DATA_W-1:0] pwdata,
  output logic [gate3_cell_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [gate3_cell_pkg::NUM_SRC-1:0] cell_in,
  input wire logic sleep_req,
  input wire logic osc_is_sysclk,
  output logic gate3_output,
  output logic fast_osc_keep,
  output logic cpu_halt
);
  logic enable;
  logic next_enable;
  gate3_cell_pkg::src_sel_t src_sel [gate3_cell_pkg::NUM_DATA];
  gate3_cell_pkg::src_sel_t next_src_sel [gate3_cell_pkg::NUM_DATA];
  logic [gate3_cell_pkg::GATE_SEL_W-1:0] gate3_input_select;
  logic [gate3_cell_pkg::GATE_SEL_W-1:0] next_gate3_input_select;
  logic [gate3_cell_pkg::NUM_DATA-1:0] data_sel;
  logic [gate3_cell_pkg::NUM_DATA-1:0] data_true_copy;
  logic [gate3_cell_pkg::NUM_DATA-1:0] data_inverted_copy;
  logic osc_selected;
  logic [gate3_cell_pkg::NUM_SRC-1:0] in_meta;
  logic [gate3_cell_pkg::NUM_SRC-1:0] in_sync;
  logic [gate3_cell_pkg::NUM_DATA-1:0] data_sync;
  logic next_fast_osc_keep;
  logic next_cpu_halt;
  logic [gate3_cell_pkg::DATA_W-1:0] next_prdata;
  logic next_pslverr;
  logic setup;
  logic wr_access;
  gate3_cell_pkg::status_s status;

  // Register access
  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign pready = 1'b1;

  // Four source multiplexers and the gate, evaluated without the clock
  always_comb begin // RULE1
    for (int i = 0; i < gate3_cell_pkg::NUM_DATA; i++) begin
      data_sel[i] = cell_in[src_sel[i]]; // RULE8
    end
    data_true_copy = data_sel;
    data_inverted_copy = ~data_sel;
    gate3_output = 1'b0; // RULE10
    for (int i = 0; i < gate3_cell_pkg::NUM_DATA; i++) begin
      gate3_output = gate3_output | (gate3_input_select[2*i+1] & data_true_copy[i]); // RULE4 RULE6
      gate3_output = gate3_output | (gate3_input_select[2*i] & data_inverted_copy[i]); // RULE5 RULE6
    end
  end

  always_comb begin
    osc_selected = 1'b0;
    for (int i = 0; i < gate3_cell_pkg::NUM_DATA; i++) begin
      osc_selected = osc_selected | (src_sel[i] == gate3_cell_pkg::FAST_OSC_SRC);
    end
  end

  // Control register, the only programmable register cleared by reset
  always_comb begin
    next_enable = enable;
    if (wr_access && paddr == gate3_cell_pkg::CTRL_OFS) begin
      next_enable = pwdata[gate3_cell_pkg::CTRL_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= gate3_cell_pkg::CTRL_RESET; // RULE9
    end else begin
      enable <= next_enable;
    end
  end

  // Selections survive reset; power-up value is undefined
  always_comb begin
    next_src_sel = src_sel;
    next_gate3_input_select = gate3_input_select;
    if (wr_access) begin
      case (paddr)
        gate3_cell_pkg::SRC_SEL0_OFS: next_src_sel[0] = pwdata[gate3_cell_pkg::SRC_SEL_W-1:0];
        gate3_cell_pkg::SRC_SEL1_OFS: next_src_sel[1] = pwdata[gate3_cell_pkg::SRC_SEL_W-1:0];
        gate3_cell_pkg::SRC_SEL2_OFS: next_src_sel[2] = pwdata[gate3_cell_pkg::SRC_SEL_W-1:0];
        gate3_cell_pkg::SRC_SEL3_OFS: next_src_sel[3] = pwdata[gate3_cell_pkg::SRC_SEL_W-1:0];
        gate3_cell_pkg::GATE3_SEL_OFS: begin
          next_gate3_input_select = pwdata[gate3_cell_pkg::GATE_SEL_W-1:0]; // RULE7
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk) begin
    src_sel <= next_src_sel; // RULE9
    gate3_input_select <= next_gate3_input_select; // RULE7 RULE9
  end

  // Sleep handling: oscillator kept alive while the cell is enabled and selects it, processor halted
  always_comb begin
    next_fast_osc_keep = sleep_req && enable && osc_selected; // RULE2
    next_cpu_halt = sleep_req; // RULE3
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_osc_keep <= 1'b0;
      cpu_halt <= 1'b0;
    end else begin
      fast_osc_keep <= next_fast_osc_keep;
      cpu_halt <= next_cpu_halt;
    end
  end

  // Input synchroniser for status readback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_meta <= '0;
      in_sync <= '0;
    end else begin
      in_meta <= cell_in;
      in_sync <= in_meta;
    end
  end

  always_comb begin
    for (int i = 0; i < gate3_cell_pkg::NUM_DATA; i++) begin
      data_sync[i] = in_sync[src_sel[i]];
    end
    status.enabled = enable;
    status.cpu_halt = cpu_halt;
    status.osc_keep = fast_osc_keep;
    status.data = data_sync;
    status.gate3 = 1'b0;
    for (int i = 0; i < gate3_cell_pkg::NUM_DATA; i++) begin
      status.gate3 = status.gate3 | (gate3_input_select[2*i+1] & data_sync[i])
                     | (gate3_input_select[2*i] & ~data_sync[i]);
    end
  end

  // Read data captured in the setup cycle, shown in the access cycle
  always_comb begin
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (setup) begin
      next_prdata = '0;
      next_pslverr = 1'b0;
      case (paddr)
        gate3_cell_pkg::CTRL_OFS: next_prdata[gate3_cell_pkg::CTRL_EN_BIT] = enable;
        gate3_cell_pkg::SRC_SEL0_OFS: next_prdata[gate3_cell_pkg::SRC_SEL_W-1:0] = src_sel[0];
        gate3_cell_pkg::SRC_SEL1_OFS: next_prdata[gate3_cell_pkg::SRC_SEL_W-1:0] = src_sel[1];
        gate3_cell_pkg::SRC_SEL2_OFS: next_prdata[gate3_cell_pkg::SRC_SEL_W-1:0] = src_sel[2];
        gate3_cell_pkg::SRC_SEL3_OFS: next_prdata[gate3_cell_pkg::SRC_SEL_W-1:0] = src_sel[3];
        gate3_cell_pkg::GATE3_SEL_OFS: begin
          next_prdata[gate3_cell_pkg::GATE_SEL_W-1:0] = gate3_input_select; // RULE7
        end
        gate3_cell_pkg::STATUS_OFS: begin
          next_prdata[gate3_cell_pkg::ST_EN_BIT:gate3_cell_pkg::ST_GATE3_BIT] = status;
        end
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Checks
  AST_TRUE4: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    (gate3_input_select[7] && data_sel[3]) |-> gate3_output)
    else $error("true copy of input 4 not admitted");

  AST_INV1: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    (gate3_input_select[0] && !data_sel[0]) |-> gate3_output)
    else $error("inverted copy of input 1 not admitted");

  AST_EXCLUDE: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (gate3_input_select == 8'h02 && !data_sel[0]) |-> !gate3_output)
    else $error("excluded copy reached gate 3");

  AST_EMPTY: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    (gate3_input_select == 8'h00) |-> !gate3_output)
    else $error("gate 3 not zero with nothing admitted");

  AST_MUX: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    (src_sel[2] == 5'h11) |-> (data_sel[2] == cell_in[5'h11]))
    else $error("data input 3 does not follow its multiplexer");

  AST_G3_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    (wr_access && paddr == gate3_cell_pkg::GATE3_SEL_OFS)
    |=> gate3_input_select == $past(pwdata[7:0]))
    else $error("gate 3 select write lost");

  AST_CTRL_CLEAR: assert property (@(posedge pclk) // RULE9
    !presetn |=> !enable)
    else $error("control not cleared by reset");

  AST_OSC_KEEP: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    (sleep_req && enable && osc_selected) |=> fast_osc_keep)
    else $error("fast oscillator not kept in sleep");

  AST_HALT: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    (sleep_req && osc_is_sysclk && enable && osc_selected) |=> (cpu_halt && fast_osc_keep))
    else $error("sleep did not halt cpu with oscillator running");

  AST_RUN_SLEEP: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    (cpu_halt && gate3_input_select == 8'h02) |-> gate3_output == data_sel[0])
    else $error("cell stopped during sleep");

  AST_INV4: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    (gate3_input_select[6] && !data_sel[3]) |-> gate3_output)
    else $error("inverted copy of input 4 not admitted");

  AST_TRUE3: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    (gate3_input_select[5] && data_sel[2]) |-> gate3_output)
    else $error("true copy of input 3 not admitted");

  AST_INV3: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    (gate3_input_select[4] && !data_sel[2]) |-> gate3_output)
    else $error("inverted copy of input 3 not admitted");

  AST_TRUE2: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    (gate3_input_select[3] && data_sel[1]) |-> gate3_output)
    else $error("true copy of input 2 not admitted");

  AST_INV2: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    (gate3_input_select[2] && !data_sel[1]) |-> gate3_output)
    else $error("inverted copy of input 2 not admitted");

  AST_TRUE1: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    (gate3_input_select[1] && data_sel[0]) |-> gate3_output)
    else $error("true copy of input 1 not admitted");

  AST_EXCL_INV1: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (gate3_input_select == 8'h01 && data_sel[0]) |-> !gate3_output)
    else $error("only inverted input 1 admitted but gate 3 high");

  AST_EXCL_INV2: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (gate3_input_select == 8'h04 && data_sel[1]) |-> !gate3_output)
    else $error("only inverted input 2 admitted but gate 3 high");

  AST_EXCL_TRUE2: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (gate3_input_select == 8'h08 && !data_sel[1]) |-> !gate3_output)
    else $error("only true input 2 admitted but gate 3 high");

  AST_EXCL_INV3: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (gate3_input_select == 8'h10 && data_sel[2]) |-> !gate3_output)
    else $error("only inverted input 3 admitted but gate 3 high");

  AST_EXCL_TRUE3: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (gate3_input_select == 8'h20 && !data_sel[2]) |-> !gate3_output)
    else $error("only true input 3 admitted but gate 3 high");

  AST_EXCL_INV4: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (gate3_input_select == 8'h40 && data_sel[3]) |-> !gate3_output)
    else $error("only inverted input 4 admitted but gate 3 high");

  AST_EXCL_TRUE4: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (gate3_input_select == 8'h80 && !data_sel[3]) |-> !gate3_output)
    else $error("only true input 4 admitted but gate 3 high");

  AST_PREADY: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    (psel && penable) |-> pready)
    else $error("access phase without ready");

  AST_SLVERR: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    (setup && paddr > gate3_cell_pkg::STATUS_OFS) |=> pslverr)
    else $error("unmapped access without error");

  AST_G3_NOERR: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    (setup && paddr == gate3_cell_pkg::GATE3_SEL_OFS) |=> !pslverr)
    else $error("gate 3 select access flagged as error");

  AST_RD_G3: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    (setup && paddr == gate3_cell_pkg::GATE3_SEL_OFS) |=> (prdata == {24'h0, $past(gate3_input_select)}))
    else $error("gate 3 select read back wrong");

  AST_SRC_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    (wr_access && paddr == gate3_cell_pkg::SRC_SEL2_OFS)
    |=> (src_sel[2] == $past(pwdata[gate3_cell_pkg::SRC_SEL_W-1:0])))
    else $error("source select 3 write lost");

  AST_CTRL_EN: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    (wr_access && paddr == gate3_cell_pkg::CTRL_OFS)
    |=> (enable == $past(pwdata[gate3_cell_pkg::CTRL_EN_BIT])))
    else $error("control enable write lost");

  AST_HALT_OFF: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    !sleep_req |=> !cpu_halt)
    else $error("cpu halted while awake");

  AST_KEEP_OFF: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    !enable |=> !fast_osc_keep)
    else $error("oscillator kept while cell disabled");

  AST_KEEP_NOSEL: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    !osc_selected |=> !fast_osc_keep)
    else $error("oscillator kept while not selected");
endmodule : gate3_cell

// file: signal_source.sv
`timescale 1ns/1ps
module signal_source (
  input wire logic pclk,
  input wire logic [31:0] pattern,
  input wire logic osc_run,
  output logic [31:0] cell_in
);
  logic osc = 1'h0;
  // Oscillator source toggles only while it is asked to run
  always_ff @(posedge pclk) begin
    osc <= osc_run ? ~osc : 1'h0;
  end
  assign cell_in = {pattern[31], pattern[30] ^ osc, pattern[29:0]};
endmodule : signal_source

// file: logic_cell_gate3_select_test.sv
`timescale 1ns/1ps
module logic_cell_gate3_select_test;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic sleep_req = 1'h0;
  logic osc_run = 1'h0;
  logic osc_is_sysclk = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] pattern = 32'h0;
  logic [31:0] prdata, cell_in, rd;
  logic pready, pslverr, gate3_output, fast_osc_keep, cpu_halt, last_err;
  logic [7:0] gsel;
  int error_cnt = 0;
  int comparisons = 0;
  int seed = 7;
  int src[$];

  gate3_cell gate3_cell_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cell_in(cell_in), .sleep_req(sleep_req), .osc_is_sysclk(osc_is_sysclk),
    .gate3_output(gate3_output), .fast_osc_keep(fast_osc_keep), .cpu_halt(cpu_halt));
  signal_source signal_source_inst (.pclk(pclk), .pattern(pattern), .osc_run(osc_run),
    .cell_in(cell_in));

  initial begin
    forever #2.5 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      complete_run();
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  function automatic logic model_g3(input logic [7:0] g, input logic [31:0] c);
    logic r;
    r = 1'h0;
    for (int k = 0; k < 4; k++) r = r | (g[2*k+1] & c[src[k]]) | (g[2*k] & ~c[src[k]]);
    return r;
  endfunction : model_g3

  task automatic program_cell();
    for (int k = 0; k < 4; k++) apb(1'h1, gate3_cell_pkg::SRC_SEL0_OFS + 8'(4*k), 32'(src[k]));
    apb(1'h1, gate3_cell_pkg::GATE3_SEL_OFS, {24'h0, gsel});
    apb(1'h0, gate3_cell_pkg::GATE3_SEL_OFS, 32'h0);
    chk("gate3_input_select", rd, {24'h0, gsel});
  endtask : program_cell

  task automatic test_g3(input int n);
    repeat (n) begin
      @(posedge pclk);
      pattern <= $random(seed);
      #1;
      chk("gate3_output", 32'(gate3_output), 32'(model_g3(gsel, cell_in)));
    end
  endtask : test_g3

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    src = '{3, 9, 17, 25};
    gsel = 8'h00;
    program_cell();
    test_g3(4);
    $display("Test none admitted done");
    for (int b = 0; b < 8; b++) begin
      gsel = 8'h01 << b;
      program_cell();
      test_g3(6);
    end
    $display("Test single bits done");
    repeat (10) begin
      for (int k = 0; k < 4; k++) src[k] = $random(seed) & 31;
      gsel = 8'($random(seed));
      program_cell();
      test_g3(4);
    end
    $display("Test random done");
    repeat (3) @(posedge pclk);
    apb(1'h0, gate3_cell_pkg::STATUS_OFS, 32'h0);
    chk("status", rd, {24'h0, 3'h0, cell_in[src[3]], cell_in[src[2]], cell_in[src[1]],
      cell_in[src[0]], model_g3(gsel, cell_in)});
    $display("Test status done");
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, gate3_cell_pkg::GATE3_SEL_OFS, 32'h0);
    chk("gate3 kept", rd, {24'h0, gsel});
    for (int k = 0; k < 4; k++) begin
      apb(1'h0, gate3_cell_pkg::SRC_SEL0_OFS + 8'(4*k), 32'h0);
      chk("source kept", rd, 32'(src[k]));
    end
    apb(1'h0, gate3_cell_pkg::CTRL_OFS, 32'h0);
    chk("control cleared", rd, 32'h0);
    apb(1'h0, 8'h40, 32'h0);
    chk("unmapped error", 32'(last_err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("Test reset and unmapped done");
    src[0] = 30;
    gsel = 8'h02;
    program_cell();
    apb(1'h1, gate3_cell_pkg::CTRL_OFS, 32'h1);
    osc_run <= 1'h1;
    sleep_req <= 1'h1;
    osc_is_sysclk <= 1'h1;
    repeat (2) @(posedge pclk);
    #1;
    chk("cpu_halt", 32'(cpu_halt), 32'h1);
    chk("fast_osc_keep", 32'(fast_osc_keep), 32'h1);
    test_g3(6);
    apb(1'h1, gate3_cell_pkg::CTRL_OFS, 32'h0);
    repeat (2) @(posedge pclk);
    #1;
    chk("keep when disabled", 32'(fast_osc_keep), 32'h0);
    sleep_req <= 1'h0;
    osc_run <= 1'h0;
    repeat (2) @(posedge pclk);
    #1;
    chk("cpu_halt off", 32'(cpu_halt), 32'h0);
    $display("Test sleep done");
    complete_run();
  end
endmodule : logic_cell_gate3_select_test
